// *** verilog/mesh_stop_event_select.v ***
`timescale 1ns/1ns
`include "mesh_stop_event_map.vh"

// Functional notes
// - directory update: hit or miss return, non-persistent only
// - directory umask selects any or transition
// - 0xBA counts invalidate ordering stall cycles up/down
// - 0xB6 counts request ring busy cycles
// - 0xBB counts second acknowledge ring busy cycles
// - 0xB7 counts acknowledge ring busy cycles
// - 0xB8 counts data ring busy cycles
// - 0xB9 counts invalidate ring busy cycles
// - busy means passing or sunk, never injected
// - ring umask bits: left/right even/odd lanes
// - umask bits 15:8, extended select 57:32
// - up is clockwise on left, reversed right
// - first half of stops left, rest right
// - invalidate ring: bit0 left, bit2 right
// - memory read counted on counters 0-3 only
// - read class bits and channel select bits
// - read target and transgress source bits
module mesh_stop_event_select #(
    parameter NUM_CTR   = 4,              // number of counters
    parameter CTR_WIDTH = 48,             // width of each count
    parameter NUM_STOPS = 8,              // caching agent stops on the ring
    parameter STOP_W    = 4               // width of the stop index
) (
    // clock and reset
    input  wire                          clk,
    input  wire                          srst,
    // counter control, one word and one enable/clear per counter
    input  wire [NUM_CTR*`CTL_WIDTH-1:0] ctl_word,
    input  wire [NUM_CTR-1:0]            ctr_en,
    input  wire [NUM_CTR-1:0]            ctr_clr,
    // placement of this stop on the ring
    input  wire [STOP_W-1:0]             stop_index,
    // directory updates
    input  wire                          dir_upd_valid,
    input  wire                          dir_upd_hit,
    input  wire                          dir_upd_pmem,
    input  wire [5:0]                    dir_upd_trans,
    // egress ordering stalls, physical rings
    input  wire                          stall_cw,
    input  wire                          stall_ccw,
    // ring lanes: bit0 left-even, 1 left-odd, 2 right-even, 3 right-odd
    input  wire [3:0]                    req_pass,
    input  wire [3:0]                    req_sink,
    input  wire [3:0]                    ack_pass,
    input  wire [3:0]                    ack_sink,
    input  wire [3:0]                    ack2_pass,
    input  wire [3:0]                    ack2_sink,
    input  wire [3:0]                    data_pass,
    input  wire [3:0]                    data_sink,
    // invalidate ring: bit0 left, bit1 right
    input  wire [1:0]                    inv_pass,
    input  wire [1:0]                    inv_sink,
    // memory controller reads, one slot per channel
    input  wire [1:0]                    rd_valid,
    input  wire [1:0]                    rd_isochronous_class,
    input  wire [3:0]                    rd_target,
    input  wire [1:0]                    rd_from_tgr,
    // results
    output wire [NUM_CTR*CTR_WIDTH-1:0]  count,
    output reg                           order_stall_up_q,
    output reg                           order_stall_down_q,
    output reg                           stop_on_right_q
);

    // registered event inputs; one stage keeps the qualifier logic off the
    // event sources' timing paths at the cost of one cycle of latency
    reg                dir_valid_q;       // directory update seen
    reg                dir_hit_q;         // hit return (else miss)
    reg                dir_pmem_q;        // update targets persistent memory
    reg  [5:0]         dir_trans_q;       // one-hot transition
    reg  [3:0]         req_busy_q;        // request ring lanes busy
    reg  [3:0]         ack_busy_q;        // acknowledge ring lanes busy
    reg  [3:0]         ack2_busy_q;       // second acknowledge lanes busy
    reg  [3:0]         data_busy_q;       // data ring lanes busy
    reg  [1:0]         inv_busy_q;        // invalidate ring sides busy
    reg  [1:0]         rd_valid_q;        // read per channel
    reg  [1:0]         rd_isochronous_class_q;        // isochronous class per channel
    reg  [3:0]         rd_target_q;       // target per channel, 2 bits each
    reg  [1:0]         rd_from_tgr_q;     // read from transgress per channel

    // side of the ring this stop sits on
    wire               stop_on_right_d;

    // first half of the stops sits left, second half right
    assign stop_on_right_d = ({1'b0, stop_index} >= (NUM_STOPS / 2));

    // input staging; injected packets have no input, so they never count
    always @(posedge clk)
    begin
        if (srst)
        begin
            dir_valid_q        <= 1'b0;
            dir_hit_q          <= 1'b0;
            dir_pmem_q         <= 1'b0;
            dir_trans_q        <= 6'h00;
            req_busy_q         <= 4'h0;
            ack_busy_q         <= 4'h0;
            ack2_busy_q        <= 4'h0;
            data_busy_q        <= 4'h0;
            inv_busy_q         <= 2'h0;
            rd_valid_q         <= 2'h0;
            rd_isochronous_class_q         <= 2'h0;
            rd_target_q        <= 4'h0;
            rd_from_tgr_q      <= 2'h0;
            order_stall_up_q   <= 1'b0;
            order_stall_down_q <= 1'b0;
            stop_on_right_q    <= 1'b0;
        end
        else
        begin
            dir_valid_q        <= dir_upd_valid;
            dir_hit_q          <= dir_upd_hit;
            dir_pmem_q         <= dir_upd_pmem;
            dir_trans_q        <= dir_upd_trans;
            // a lane is busy for pass-through or sunk packets
            req_busy_q         <= req_pass | req_sink;
            ack_busy_q         <= ack_pass | ack_sink;
            ack2_busy_q        <= ack2_pass | ack2_sink;
            data_busy_q        <= data_pass | data_sink;
            inv_busy_q         <= inv_pass | inv_sink;
            rd_valid_q         <= rd_valid;
            rd_isochronous_class_q         <= rd_isochronous_class;
            rd_target_q        <= rd_target;
            rd_from_tgr_q      <= rd_from_tgr;
            stop_on_right_q    <= stop_on_right_d;
            // up is clockwise on the left side, counter-clockwise on the right
            order_stall_up_q   <= stop_on_right_d ? stall_ccw : stall_cw;
            order_stall_down_q <= stop_on_right_d ? stall_cw : stall_ccw;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CTR; gi = gi + 1)
        begin : g_ctr
            // fields of this counter's control word
            wire [7:0]  evsel;            // event code
            wire [7:0]  umask;            // unit mask
            wire [25:0] xsel;             // extended select
            wire        restricted_ok;    // counter may host restricted events
            wire        dir_match;        // directory update qualifies
            wire        rd_match;         // memory read qualifies
            wire [1:0]  rd_ch_match;      // per channel read qualifies
            wire [3:0]  lane_sel;         // lanes chosen for four-lane rings
            reg         inc;              // qualified event this cycle

            assign evsel = ctl_word[gi*`CTL_WIDTH+`EVSEL_LSB +: 8];
            assign umask = ctl_word[gi*`CTL_WIDTH+`UMASK_LSB +: 8];
            assign xsel  = ctl_word[gi*`CTL_WIDTH+`XSEL_LSB +: 26];

            // restricted events count nothing on higher counters
            assign restricted_ok = (gi < `RESTRICTED_CTR_LIMIT);

            // non-persistent only; hit via xsel bit0, miss via xsel bit1
            assign dir_match = dir_valid_q && !dir_pmem_q
                && ((dir_hit_q && xsel[`XS_BIT0])
                    || (!dir_hit_q && xsel[`XS_BIT1]))
                && (umask[`UM_BIT0] || (|(umask[`UM_BIT6:`UM_BIT1]
                    & dir_trans_q)));

            // lane order already matches umask bits 0..3
            assign lane_sel = umask[`UM_BIT3:`UM_BIT0];

            genvar ch;
            for (ch = 0; ch < 2; ch = ch + 1)
            begin : g_ch
                wire [1:0] tgt;           // target of this channel's read
                assign tgt = rd_target_q[2*ch +: 2];
                // channel picked by xsel, then any selected qualifier
                assign rd_ch_match[ch] = rd_valid_q[ch] && xsel[ch]
                    && ((umask[`UM_BIT0] && !rd_isochronous_class_q[ch])
                        || (umask[`UM_BIT1] && rd_isochronous_class_q[ch])
                        || umask[`UM_BIT2]
                        || (umask[`UM_BIT3] && (tgt == `TGT_DDR_MEM))
                        || (umask[`UM_BIT4] && (tgt == `TGT_DDR_CACHE))
                        || (umask[`UM_BIT5] && (tgt == `TGT_PMEM))
                        || (umask[`UM_BIT6] && rd_from_tgr_q[ch]));
            end

            // both channels in one cycle still add one
            assign rd_match = |rd_ch_match;

            // event decode; any selected lane or qualifier adds one
            always @*
            begin
                case (evsel)
                    `EV_DIR_UPDATE:
                    begin
                        inc = restricted_ok && dir_match;
                    end
                    `EV_MC_READ:
                    begin
                        inc = restricted_ok && rd_match;
                    end
                    `EV_ORDER_STALL:
                    begin
                        inc = (umask[`UM_BIT0] && order_stall_up_q)
                            || (umask[`UM_BIT2] && order_stall_down_q);
                    end
                    `EV_REQ_RING_BUSY:
                    begin
                        inc = |(lane_sel & req_busy_q);
                    end
                    `EV_ACK2_RING_BUSY:
                    begin
                        inc = |(lane_sel & ack2_busy_q);
                    end
                    `EV_ACK_RING_BUSY:
                    begin
                        inc = |(lane_sel & ack_busy_q);
                    end
                    `EV_DATA_RING_BUSY:
                    begin
                        inc = |(lane_sel & data_busy_q);
                    end
                    `EV_INV_RING_BUSY:
                    begin
                        // single ring: left on bit0, right on bit2
                        inc = (umask[`UM_BIT0] && inv_busy_q[0])
                            || (umask[`UM_BIT2] && inv_busy_q[1]);
                    end
                    default:
                    begin
                        // unknown code counts nothing
                        inc = 1'b0;
                    end
                endcase
            end

            // the running count for this counter
            event_tally_counter #(
                .WIDTH   (CTR_WIDTH)
            ) u_tally (
                .clk     (clk),
                .srst    (srst),
                .clr     (ctr_clr[gi]),
                .en      (ctr_en[gi]),
                .inc     (inc),
                .count_q (count[gi*CTR_WIDTH +: CTR_WIDTH])
            );
        end
    endgenerate

endmodule // mesh_stop_event_select

// *** verilog/mesh_stop_event_map.vh ***
`ifndef MESH_STOP_EVENT_MAP_VH
`define MESH_STOP_EVENT_MAP_VH

// event codes, control word bits [7:0]
`define EVSEL_LSB           0
`define EVSEL_MSB           7
`define EV_DIR_UPDATE       8'h21
`define EV_MC_READ          8'h24
`define EV_ORDER_STALL      8'hba
`define EV_REQ_RING_BUSY    8'hb6
`define EV_ACK_RING_BUSY    8'hb7
`define EV_DATA_RING_BUSY   8'hb8
`define EV_INV_RING_BUSY    8'hb9
`define EV_ACK2_RING_BUSY   8'hbb

// qualifier fields of the control word
`define UMASK_LSB           8
`define UMASK_MSB           15
`define XSEL_LSB            32
`define XSEL_MSB            57
`define CTL_WIDTH           64

// unit-mask bit positions (within the 8-bit field)
`define UM_BIT0             0
`define UM_BIT1             1
`define UM_BIT2             2
`define UM_BIT3             3
`define UM_BIT4             4
`define UM_BIT5             5
`define UM_BIT6             6

// extended select bit positions (within the 26-bit field)
`define XS_BIT0             0
`define XS_BIT1             1

// counters that may host the restricted events are 0 up to this bound minus one
`define RESTRICTED_CTR_LIMIT 4

// memory read target encoding
`define TGT_DDR_MEM         2'h0
`define TGT_DDR_CACHE       2'h1
`define TGT_PMEM            2'h2

// reset value of every count
`define COUNT_RESET         1'b0

`endif

// *** verilog/event_tally_counter.v ***
`timescale 1ns/1ns
`include "mesh_stop_event_map.vh"

module event_tally_counter #(
    parameter WIDTH = 48                  // count width
) (
    // clock and reset
    input  wire             clk,
    input  wire             srst,
    // control
    input  wire             clr,          // clears the count, wins over inc
    input  wire             en,           // counting enabled
    input  wire             inc,          // qualified event this cycle
    // result
    output reg  [WIDTH-1:0] count_q       // running count
);

    // one increment per cycle at most; wraps silently at full scale
    always @(posedge clk)
    begin
        if (srst || clr)
        begin
            count_q <= {WIDTH{`COUNT_RESET}};
        end
        else if (en && inc)
        begin
            count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule // event_tally_counter

// *** test/mesh_stop_event_properties.sv ***
`timescale 1ns/1ns
`include "mesh_stop_event_map.vh"

// watches counter 0 with the request ring, counter 4 for the restricted codes
module mesh_stop_event_checker #(
    parameter NUM_CTR   = 5,
    parameter CTR_WIDTH = 16,
    parameter NUM_STOPS = 8,
    parameter STOP_W    = 4
) (
    input wire                          clk,
    input wire                          srst,
    input wire [NUM_CTR*`CTL_WIDTH-1:0] ctl_word,
    input wire [NUM_CTR-1:0]            ctr_en,
    input wire [NUM_CTR-1:0]            ctr_clr,
    input wire [STOP_W-1:0]             stop_index,
    input wire                          stall_cw,
    input wire                          stall_ccw,
    input wire [3:0]                    req_pass,
    input wire [3:0]                    req_sink,
    input wire [NUM_CTR*CTR_WIDTH-1:0]  count,
    input wire                          order_stall_up_q,
    input wire                          order_stall_down_q,
    input wire                          stop_on_right_q
);
    wire [CTR_WIDTH-1:0] cnt0  = count[CTR_WIDTH-1:0];             // first count
    wire [CTR_WIDTH-1:0] cnt4  = count[5*CTR_WIDTH-1:4*CTR_WIDTH]; // restricted slot
    wire [7:0]           code4 = ctl_word[263:256];                // code of counter 4
    wire [7:0]           um0   = ctl_word[15:8];                   // unit mask of counter 0
    wire                 right = stop_index >= NUM_STOPS/2;        // side of this stop
    wire                 busy0 = req_pass[0] | req_sink[0];        // lane 0 in use
    wire                 cfg0  = ctl_word[7:0] == 8'hb6 && ctr_en[0] && !ctr_clr[0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // event staged one edge, decoded against the control at the next edge
    sequence busy_seen; busy0 ##1 (cfg0 && um0[0]); endsequence
    sequence idle_seen; !(|req_pass) && !(|req_sink) ##1 cfg0; endsequence

    AST_RESET: assert property (disable iff (1'b0) srst |=> cnt0 == '0
        && !order_stall_up_q && !order_stall_down_q && !stop_on_right_q)
        else $error("state not cleared by reset");
    AST_BUSY_COUNT: assert property (busy_seen |=> cnt0 == $past(cnt0) + 1'b1)
        else $error("busy lane cycle not counted");
    AST_IDLE_HOLD: assert property (idle_seen |=> $stable(cnt0))
        else $error("count moved with the ring idle");
    AST_CLEAR: assert property (ctr_clr[0] |=> cnt0 == '0)
        else $error("clear did not zero the count");
    AST_DISABLED: assert property (!ctr_en[0] && !ctr_clr[0] |=> $stable(cnt0))
        else $error("disabled counter moved");
    // several qualifiers still give one step per cycle
    AST_STEP_ONE: assert property (!ctr_clr[0] |=>
        cnt0 == $past(cnt0) || cnt0 == $past(cnt0) + 1'b1)
        else $error("count stepped by more than one");
    AST_RESTRICTED: assert property ((code4 == 8'h21 || code4 == 8'h24)
        && !ctr_clr[4] |=> $stable(cnt4))
        else $error("restricted event counted on counter 4");
    AST_SIDE: assert property (1'b1 |=> stop_on_right_q == $past(right))
        else $error("side of stop wrong");
    AST_UP_MAP: assert property ($stable(stop_index) |=>
        order_stall_up_q == ($past(right) ? $past(stall_ccw) : $past(stall_cw)))
        else $error("up stall mapped to wrong ring");
    AST_DOWN_MAP: assert property ($stable(stop_index) |=>
        order_stall_down_q == ($past(right) ? $past(stall_cw) : $past(stall_ccw)))
        else $error("down stall mapped to wrong ring");
endmodule // mesh_stop_event_checker

bind mesh_stop_event_select mesh_stop_event_checker #(.NUM_CTR(NUM_CTR),
    .CTR_WIDTH(CTR_WIDTH), .NUM_STOPS(NUM_STOPS), .STOP_W(STOP_W)) u_chk (
    .clk(clk), .srst(srst), .ctl_word(ctl_word), .ctr_en(ctr_en), .ctr_clr(ctr_clr),
    .stop_index(stop_index), .stall_cw(stall_cw), .stall_ccw(stall_ccw),
    .req_pass(req_pass), .req_sink(req_sink), .count(count),
    .order_stall_up_q(order_stall_up_q), .order_stall_down_q(order_stall_down_q),
    .stop_on_right_q(stop_on_right_q));

// *** test/tb.sv ***
`timescale 1ns/1ns

module tb;
    reg         clk = 1'b0;              // 50 MHz
    reg         srst = 1'b1;             // held for 20 cycles
    reg [319:0] ctl_word = '0;           // five control words
    reg [4:0]   ctr_en = '0, ctr_clr = '0;
    reg [3:0]   stop_index = 4'h0;       // left side at start
    reg         dir_upd_valid = 1'b0, dir_upd_hit = 1'b0, dir_upd_pmem = 1'b0;
    reg [5:0]   dir_upd_trans = 6'h00;
    reg         stall_cw = 1'b0, stall_ccw = 1'b0;
    reg [3:0]   req_pass = '0, req_sink = '0, ack_pass = '0, ack_sink = '0;
    reg [3:0]   ack2_pass = '0, ack2_sink = '0, data_pass = '0, data_sink = '0;
    reg [1:0]   inv_pass = '0, inv_sink = '0, rd_valid = '0, rd_isochronous_class = '0, rd_from_tgr = '0;
    reg [3:0]   rd_target = 4'h0;        // two bits per channel
    wire [79:0] count;                   // five 16-bit counts
    wire        order_stall_up_q, order_stall_down_q, stop_on_right_q;
    integer     miscompares = 0, check_count = 0;

    // five counters so that slot 4 shows the restriction to slots 0-3
    mesh_stop_event_select #(.NUM_CTR(5), .CTR_WIDTH(16), .NUM_STOPS(8), .STOP_W(4)) dut (
        .clk(clk), .srst(srst), .ctl_word(ctl_word), .ctr_en(ctr_en), .ctr_clr(ctr_clr),
        .stop_index(stop_index), .dir_upd_valid(dir_upd_valid), .dir_upd_hit(dir_upd_hit),
        .dir_upd_pmem(dir_upd_pmem), .dir_upd_trans(dir_upd_trans), .stall_cw(stall_cw),
        .stall_ccw(stall_ccw), .req_pass(req_pass), .req_sink(req_sink),
        .ack_pass(ack_pass), .ack_sink(ack_sink), .ack2_pass(ack2_pass),
        .ack2_sink(ack2_sink), .data_pass(data_pass), .data_sink(data_sink),
        .inv_pass(inv_pass), .inv_sink(inv_sink), .rd_valid(rd_valid), .rd_isochronous_class(rd_isochronous_class),
        .rd_target(rd_target), .rd_from_tgr(rd_from_tgr), .count(count),
        .order_stall_up_q(order_stall_up_q), .order_stall_down_q(order_stall_down_q),
        .stop_on_right_q(stop_on_right_q));

    always #10 clk = ~clk;

    // inputs move 1 ns after the edge, away from sampling
    task step; begin @(posedge clk); #1; end endtask
    task clear_all; begin ctr_clr = 5'h1f; step; ctr_clr = 5'h00; end endtask
    task setc(input integer i, input [7:0] c, input [7:0] um, input [25:0] xs, input en);
        begin
            ctl_word[64*i +: 64] = {6'h00, xs, 16'h0000, um, c};
            ctr_en[i] = en;
        end
    endtask
    task chk_cnt(input integer i, input [15:0] exp);
        begin
            check_count++;
            if (count[16*i +: 16] !== exp)
            begin
                miscompares++;
                $display("unexpected at %0t: count %0d is %h not %h", $time, i,
                    count[16*i +: 16], exp);
            end
        end
    endtask
    task chk_bit(input b, input exp);
        begin
            check_count++;
            if (b !== exp)
            begin
                miscompares++;
                $display("unexpected at %0t: flag is %b not %b", $time, b, exp);
            end
        end
    endtask
    // one cycle of lane activity on the ring that code c watches
    task lanes(input [7:0] c, input [3:0] p, input [3:0] s);
        begin
            {req_pass, req_sink}   = (c == 8'hb6) ? {p, s} : 8'h00;
            {ack_pass, ack_sink}   = (c == 8'hb7) ? {p, s} : 8'h00;
            {data_pass, data_sink} = (c == 8'hb8) ? {p, s} : 8'h00;
            {ack2_pass, ack2_sink} = (c == 8'hbb) ? {p, s} : 8'h00;
            step;
        end
    endtask
    task t_ring;
        integer k, l;
        reg [7:0] c;
        begin
            for (k = 0; k < 4; k++)
                for (l = 0; l < 4; l++)
                begin
                    c = (k == 3) ? 8'hbb : 8'hb6 + k[7:0];
                    setc(0, c, 8'h01 << l, 26'h0, 1'b1);
                    setc(1, c, 8'h0f, 26'h0, 1'b1);
                    setc(2, c, 8'h0f, 26'h0, 1'b0);
                    // a code outside the decoded set must never count
                    setc(3, 8'hbc, 8'h0f, 26'h0, 1'b1);
                    clear_all;
                    lanes(c, 4'h1 << l, 4'h0);
                    lanes(c, 4'h0, 4'h1 << l);
                    lanes(c, 4'h1 << ((l + 1) % 4), 4'h0);
                    lanes(c, 4'h1 << l, 4'h1 << l);
                    lanes(c, 4'h0, 4'h0);
                    step;
                    chk_cnt(0, 16'h0003);
                    chk_cnt(1, 16'h0004);
                    chk_cnt(2, 16'h0000);
                    chk_cnt(3, 16'h0000);
                end
            ctr_en = 5'h00;
            $display("ring occupancy test done");
        end
    endtask
    task t_inv;
        begin
            setc(0, 8'hb9, 8'h01, 26'h0, 1'b1);
            setc(1, 8'hb9, 8'h04, 26'h0, 1'b1);
            clear_all;
            inv_pass = 2'b01; step;
            inv_pass = 2'b00; inv_sink = 2'b10; step;
            inv_sink = 2'b00; inv_pass = 2'b10; step;
            inv_pass = 2'b00; step; step;
            chk_cnt(0, 16'h0001);
            chk_cnt(1, 16'h0002);
            $display("invalidate ring test done");
        end
    endtask
    task dir(input h, input pm, input [5:0] tr);
        begin
            dir_upd_valid = 1'b1; dir_upd_hit = h; dir_upd_pmem = pm; dir_upd_trans = tr;
            step;
        end
    endtask
    task t_dir;
        begin
            setc(0, 8'h21, 8'h01, 26'h1, 1'b1);
            setc(1, 8'h21, 8'h02, 26'h2, 1'b1);
            setc(2, 8'h21, 8'h04, 26'h1, 1'b1);
            setc(4, 8'h21, 8'h01, 26'h1, 1'b1);
            clear_all;
            dir(1'b1, 1'b0, 6'h01); dir(1'b0, 1'b0, 6'h01);
            dir(1'b1, 1'b1, 6'h02); dir(1'b1, 1'b0, 6'h02);
            dir_upd_valid = 1'b0; step; step;
            chk_cnt(0, 16'h0002);
            chk_cnt(1, 16'h0001);
            chk_cnt(2, 16'h0001);
            chk_cnt(4, 16'h0000);
            $display("directory update test done");
        end
    endtask
    task t_rd;
        begin
            setc(0, 8'h24, 8'h01, 26'h1, 1'b1);
            setc(1, 8'h24, 8'h02, 26'h2, 1'b1);
            setc(2, 8'h24, 8'h04, 26'h3, 1'b1);
            setc(3, 8'h24, 8'h60, 26'h3, 1'b1);
            setc(4, 8'h24, 8'h04, 26'h3, 1'b1);
            clear_all;
            rd_valid = 2'b11; rd_isochronous_class = 2'b10; rd_target = 4'h2; step;
            rd_valid = 2'b01; rd_isochronous_class = 2'b00; rd_target = 4'h0; rd_from_tgr = 2'b01; step;
            rd_valid = 2'b00; rd_from_tgr = 2'b00; step; step;
            chk_cnt(0, 16'h0002);
            chk_cnt(1, 16'h0001);
            chk_cnt(2, 16'h0002);
            chk_cnt(3, 16'h0002);
            chk_cnt(4, 16'h0000);
            $display("memory read test done");
        end
    endtask
    // last left stop, then the first right stop
    task t_stall;
        integer s;
        begin
            ctr_en = 5'h00;
            setc(0, 8'hba, 8'h01, 26'h0, 1'b1);
            setc(1, 8'hba, 8'h04, 26'h0, 1'b1);
            for (s = 0; s < 2; s++)
            begin
                stop_index = s ? 4'h4 : 4'h3;
                clear_all; step;
                stall_cw = 1'b1; step;
                chk_bit(order_stall_up_q, !s);
                chk_bit(order_stall_down_q, s[0]);
                stall_cw = 1'b0; step; step;
                chk_bit(stop_on_right_q, s[0]);
                chk_cnt(0, s ? 16'h0000 : 16'h0001);
                chk_cnt(1, s ? 16'h0001 : 16'h0000);
            end
            $display("ordering stall test done");
        end
    endtask
    task conclude;
        begin
            $display("checks %0d, mismatches %0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    // main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        #1 srst = 1'b0;
        chk_cnt(0, 16'h0000);
        t_ring; t_inv; t_dir; t_rd; t_stall;
        conclude;
    end
    // watchdog, far beyond the 160 cycles the tests need
    initial
    begin
        #200000;
        miscompares++;
        conclude;
    end
endmodule // tb
